// >>> sap_regs.svh
// Parameter numbers, field limits, reset values and timing counts of the axis parameter bank.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef SAP_REGS_SVH
`define SAP_REGS_SVH

// Parameter numbers as carried in the command frame.
`define SAP_P_STALL_THR 8'hae
`define SAP_P_SENSE_RANGE 8'hb3
`define SAP_P_CUR_ACTUAL 8'hb4
`define SAP_P_STALL_SPEED 8'hb5
`define SAP_P_ADAPT_SPEED 8'hb6
`define SAP_P_PWM_LIMIT 8'hba
`define SAP_P_PWM_GRAD 8'hbb
`define SAP_P_PWM_AMPL 8'hbc
`define SAP_P_PWM_SCALE 8'hbd
`define SAP_P_PWM_FREQ 8'hbf
`define SAP_P_PWM_AUTO 8'hc0
`define SAP_P_HOME_THR 8'hc1
`define SAP_P_HOME_SPEED 8'hc2
`define SAP_P_HOME_MIN 8'hc3
`define SAP_P_END_DIST 8'hc4
`define SAP_P_LOAD 8'hce
`define SAP_P_STALL_FLAG 8'hcf
`define SAP_P_FAULTS 8'hd0

// Field widths.
`define SAP_W_THR 7
`define SAP_W_SPEED 23
`define SAP_W_DIST 31
`define SAP_W_LOAD 10

// Largest speed, 7999774 steps per second.
`define SAP_SPEED_MAX 32'h007a111e
// Lowest signed threshold word for the reference search, -64, which is refused there.
`define SAP_HOME_THR_BAD 32'hffffffc0

// Reset values.
`define SAP_RST_SENSE 1'h1
`define SAP_RST_THR 7'h00
`define SAP_RST_SPEED 23'h000000
`define SAP_RST_GRAD 4'h0
`define SAP_RST_AMPL 8'h00
`define SAP_RST_FREQ 2'h0
`define SAP_RST_AUTO 1'h0

// Fault bit positions in the driver error byte.
`define SAP_F_STANDSTILL 7

// Stand-still window, 2^20 clock cycles.
`define SAP_STANDSTILL_CYC 21'h100000

`endif

// >>> sap_pkg.sv
// Types shared by the axis parameter bank: command and answer frames and the homing states.
// Assumes sap_regs.svh is on the include path.
package sap_pkg;
    `include "sap_regs.svh"

    // Operation carried by one command frame.
    typedef enum logic [1:0] {
        SAP_OP_READ = 2'b00,
        SAP_OP_WRITE = 2'b01,
        SAP_OP_HOME = 2'b10
    } sap_op_e;

    // Reference search progress.
    typedef enum logic {
        SAP_HOME_IDLE = 1'b0,
        SAP_HOME_BUSY = 1'b1
    } sap_home_e;

    // One decoded command frame from the module bus.
    typedef struct packed {
        sap_op_e op;
        logic [7:0] param;
        logic [31:0] value;
    } sap_cmd_s;

    // Answer to one command frame.
    typedef struct packed {
        logic ok;
        logic [31:0] value;
    } sap_rsp_s;
endpackage

// >>> sap_sync.sv
// Two-stage synchroniser for a group of level inputs from pins.
// Assumes the inputs change slowly compared with the clock.
`timescale 1ns/1ps
module sap_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // First stage; read only by the second stage to keep metastability contained.
    logic [W-1:0] meta;

    // Both stages clear on reset and then follow the pins.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// >>> sap_above.sv
// Unsigned magnitude compare used for every speed threshold.
// Assumes both operands come from logic on the same clock.
`timescale 1ns/1ps
module sap_above #(
    parameter int W = 23
) (
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    output logic above_o
);
    // High when a is strictly greater than b; equality counts as not above.
    assign above_o = (a_i > b_i);
endmodule

// >>> sap_axis_bank.sv
// Axis parameter bank of a single-axis stepper module: stall, adaptive current,
// quiet PWM and reference search settings, with their status readouts.
// Assumes command frames arrive decoded, one per cycle at most, on the module clock;
// fault levels arrive on pins, load and speed come from driver logic on this clock.
`timescale 1ns/1ps
module sap_axis_bank
    import sap_pkg::*;
#(
    parameter logic [20:0] STANDSTILL_CYCLES = `SAP_STANDSTILL_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Command frame port.
    input wire logic cmd_valid_i,
    input wire sap_cmd_s cmd_i,
    output logic rsp_valid_o,
    output sap_rsp_s rsp_o,
    // Driver side status from logic on this clock.
    input wire logic [22:0] actual_speed_i,
    input wire logic [9:0] load_i,
    input wire logic [4:0] current_scale_i,
    input wire logic [7:0] pwm_scale_i,
    input wire logic step_pulse_i,
    // Driver fault levels from pins, bits 0 to 6 of the error byte.
    input wire logic [6:0] fault_pins_i,
    // Reference search motion logic.
    input wire logic homing_done_i,
    input wire logic [30:0] homing_distance_i,
    // Settings and controls towards the driver.
    output logic sense_range_o,
    output logic [6:0] active_stall_threshold_o,
    output logic stop_motor_o,
    output logic adaptive_current_en_o,
    output logic quiet_pwm_en_o,
    output logic [3:0] pwm_gradient_o,
    output logic [7:0] pwm_amplitude_o,
    output logic [1:0] pwm_freq_o,
    output logic pwm_autoscale_o,
    output logic homing_start_o,
    output logic homing_busy_o,
    output logic [22:0] homing_speed_o
);
    // Stored writable parameters.
    logic [6:0] stall_threshold;
    logic sense_range_select;
    logic [22:0] stall_stop_speed;
    logic [22:0] adaptive_current_speed;
    logic [22:0] quiet_pwm_speed_limit;
    logic [3:0] quiet_pwm_gradient;
    logic [7:0] quiet_pwm_amplitude;
    logic [1:0] quiet_pwm_freq_select;
    logic quiet_pwm_autoscale;
    logic [6:0] homing_stall_threshold;
    logic [22:0] homing_speed;
    logic [22:0] homing_stall_min_speed;
    // Read-only state captured by the bank.
    logic [30:0] end_stop_distance;
    logic stall_stop_flag;
    logic [7:0] driver_fault_flags;
    // Homing state.
    sap_home_e home_state;
    // Stand-still cycle counter, saturates at the window length.
    logic [20:0] idle_cycles;
    // Synchronised fault pins.
    logic [6:0] fault_sync;
    // Speed compare results.
    logic above_stop;
    logic above_adapt;
    logic above_pwm;
    logic below_pwm;
    logic above_home_min;
    // Decoded command.
    logic wr;
    logic rd;
    logic [31:0] v;
    logic in_thr;
    logic in_speed;
    logic stall_cond;
    logic wr_ok;
    logic [31:0] next_rsp_value;
    logic next_rsp_ok;

    // Command decode shared by every parameter process.
    assign wr = cmd_valid_i && (cmd_i.op == SAP_OP_WRITE);
    assign rd = cmd_valid_i && (cmd_i.op == SAP_OP_READ);
    assign v = cmd_i.value;
    // A signed seven bit value has all upper bits equal to its sign.
    assign in_thr = (v[31:6] == 26'h0000000) || (v[31:6] == 26'h3ffffff);
    assign in_speed = (v <= `SAP_SPEED_MAX);

    // Fault pins cross into the clock domain before anything looks at them.
    sap_sync #(.W(7)) u_fault_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(fault_pins_i),
        .q_o(fault_sync)
    );

    // Stall stop speed compare.
    sap_above #(.W(`SAP_W_SPEED)) u_cmp_stop (
        .a_i(actual_speed_i),
        .b_i(stall_stop_speed),
        .above_o(above_stop)
    );

    // Adaptive current speed compare.
    sap_above #(.W(`SAP_W_SPEED)) u_cmp_adapt (
        .a_i(actual_speed_i),
        .b_i(adaptive_current_speed),
        .above_o(above_adapt)
    );

    // Quiet PWM limit, above side.
    sap_above #(.W(`SAP_W_SPEED)) u_cmp_pwm_hi (
        .a_i(actual_speed_i),
        .b_i(quiet_pwm_speed_limit),
        .above_o(above_pwm)
    );

    // Quiet PWM limit, below side; equality leaves the mode as it was.
    sap_above #(.W(`SAP_W_SPEED)) u_cmp_pwm_lo (
        .a_i(quiet_pwm_speed_limit),
        .b_i(actual_speed_i),
        .above_o(below_pwm)
    );

    // Reference search minimum speed compare.
    sap_above #(.W(`SAP_W_SPEED)) u_cmp_home (
        .a_i(actual_speed_i),
        .b_i(homing_stall_min_speed),
        .above_o(above_home_min)
    );

    // Range check per parameter; read-only and unknown numbers never pass.
    always_comb begin
        wr_ok = 1'b0;
        case (cmd_i.param)
            `SAP_P_STALL_THR: wr_ok = in_thr;
            `SAP_P_SENSE_RANGE: wr_ok = (v[31:1] == 31'h00000000);
            `SAP_P_STALL_SPEED: wr_ok = in_speed;
            `SAP_P_ADAPT_SPEED: wr_ok = in_speed;
            `SAP_P_PWM_LIMIT: wr_ok = in_speed;
            `SAP_P_PWM_GRAD: wr_ok = (v[31:4] == 28'h0000000);
            `SAP_P_PWM_AMPL: wr_ok = (v[31:8] == 24'h000000);
            `SAP_P_PWM_FREQ: wr_ok = (v[31:2] == 30'h00000000);
            `SAP_P_PWM_AUTO: wr_ok = (v[31:1] == 31'h00000000);
            // Minus 64 is legal for the run threshold but not for homing.
            `SAP_P_HOME_THR: wr_ok = in_thr && (v != `SAP_HOME_THR_BAD);
            `SAP_P_HOME_SPEED: wr_ok = in_speed;
            `SAP_P_HOME_MIN: wr_ok = in_speed;
            default: wr_ok = 1'b0;
        endcase
    end

    // Stall thresholds and sense range.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stall_threshold <= `SAP_RST_THR;
            sense_range_select <= `SAP_RST_SENSE;
            homing_stall_threshold <= `SAP_RST_THR;
        end else if (wr && wr_ok) begin
            case (cmd_i.param)
                `SAP_P_STALL_THR: stall_threshold <= v[6:0];
                `SAP_P_SENSE_RANGE: sense_range_select <= v[0];
                `SAP_P_HOME_THR: homing_stall_threshold <= v[6:0];
                default: begin
                    // Other parameters are held elsewhere.
                end
            endcase
        end
    end

    // Speed thresholds.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stall_stop_speed <= `SAP_RST_SPEED;
            adaptive_current_speed <= `SAP_RST_SPEED;
            quiet_pwm_speed_limit <= `SAP_RST_SPEED;
            homing_speed <= `SAP_RST_SPEED;
            homing_stall_min_speed <= `SAP_RST_SPEED;
        end else if (wr && wr_ok) begin
            case (cmd_i.param)
                `SAP_P_STALL_SPEED: stall_stop_speed <= v[22:0];
                `SAP_P_ADAPT_SPEED: adaptive_current_speed <= v[22:0];
                `SAP_P_PWM_LIMIT: quiet_pwm_speed_limit <= v[22:0];
                `SAP_P_HOME_SPEED: homing_speed <= v[22:0];
                `SAP_P_HOME_MIN: homing_stall_min_speed <= v[22:0];
                default: begin
                    // Other parameters are held elsewhere.
                end
            endcase
        end
    end

    // Quiet PWM settings.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            quiet_pwm_gradient <= `SAP_RST_GRAD;
            quiet_pwm_amplitude <= `SAP_RST_AMPL;
            quiet_pwm_freq_select <= `SAP_RST_FREQ;
            quiet_pwm_autoscale <= `SAP_RST_AUTO;
        end else if (wr && wr_ok) begin
            case (cmd_i.param)
                `SAP_P_PWM_GRAD: quiet_pwm_gradient <= v[3:0];
                `SAP_P_PWM_AMPL: quiet_pwm_amplitude <= v[7:0];
                `SAP_P_PWM_FREQ: quiet_pwm_freq_select <= v[1:0];
                `SAP_P_PWM_AUTO: quiet_pwm_autoscale <= v[0];
                default: begin
                    // Other parameters are held elsewhere.
                end
            endcase
        end
    end

    // Reference search sequencing; the motion itself runs outside and reports done.
    // A second start while busy is ignored so the distance is never half measured.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            home_state <= SAP_HOME_IDLE;
            homing_start_o <= 1'b0;
            end_stop_distance <= 31'h00000000;
        end else begin
            homing_start_o <= 1'b0;
            case (home_state)
                SAP_HOME_IDLE: begin
                    if (cmd_valid_i && (cmd_i.op == SAP_OP_HOME)) begin
                        home_state <= SAP_HOME_BUSY;
                        homing_start_o <= 1'b1;
                    end
                end
                SAP_HOME_BUSY: begin
                    if (homing_done_i) begin
                        home_state <= SAP_HOME_IDLE;
                        end_stop_distance <= homing_distance_i;
                    end
                end
                default: home_state <= SAP_HOME_IDLE;
            endcase
        end
    end

    // Stall stop: zero load counts only above the speed that applies now.
    assign stall_cond = (load_i == 10'h000) &&
        ((home_state == SAP_HOME_BUSY) ? above_home_min : above_stop);

    // Stop request and active threshold to the driver.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stop_motor_o <= 1'b0;
            active_stall_threshold_o <= `SAP_RST_THR;
        end else begin
            stop_motor_o <= stall_cond;
            active_stall_threshold_o <= (home_state == SAP_HOME_BUSY) ?
                homing_stall_threshold : stall_threshold;
        end
    end

    // Stall stop flag; a new stop in the reading cycle survives the clear.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stall_stop_flag <= 1'b0;
        end else if (stall_cond) begin
            stall_stop_flag <= 1'b1;
        end else if (rd && (cmd_i.param == `SAP_P_STALL_FLAG)) begin
            stall_stop_flag <= 1'b0;
        end
    end

    // Stand-still counter: restarts on each step and saturates at the window.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idle_cycles <= 21'h000000;
        end else if (step_pulse_i) begin
            idle_cycles <= 21'h000000;
        end else if (idle_cycles < STANDSTILL_CYCLES) begin
            idle_cycles <= idle_cycles + 21'h000001;
        end
    end

    // Error byte: pin levels in bits 0 to 6, stand-still in bit 7.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            driver_fault_flags <= 8'h00;
        end else begin
            driver_fault_flags[4:0] <= fault_sync[4:0];
            driver_fault_flags[6:5] <= fault_sync[6:5];
            driver_fault_flags[`SAP_F_STANDSTILL] <=
                (idle_cycles >= STANDSTILL_CYCLES) && !step_pulse_i;
        end
    end

    // Mode enables towards the driver.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            adaptive_current_en_o <= 1'b0;
            quiet_pwm_en_o <= 1'b0;
        end else begin
            adaptive_current_en_o <= above_adapt;
            if (quiet_pwm_gradient == 4'h0) begin
                quiet_pwm_en_o <= 1'b0;
            end else if (above_pwm) begin
                quiet_pwm_en_o <= 1'b0;
            end else if (below_pwm) begin
                quiet_pwm_en_o <= 1'b1;
            end
        end
    end

    // Plain copies of the settings, registered so every output is a flop.
    // The driver uses the amplitude only while autoscale is off.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sense_range_o <= `SAP_RST_SENSE;
            pwm_gradient_o <= `SAP_RST_GRAD;
            pwm_amplitude_o <= `SAP_RST_AMPL;
            pwm_freq_o <= `SAP_RST_FREQ;
            pwm_autoscale_o <= `SAP_RST_AUTO;
            homing_busy_o <= 1'b0;
            homing_speed_o <= `SAP_RST_SPEED;
        end else begin
            sense_range_o <= sense_range_select;
            pwm_gradient_o <= quiet_pwm_gradient;
            pwm_amplitude_o <= quiet_pwm_amplitude;
            pwm_freq_o <= quiet_pwm_freq_select;
            pwm_autoscale_o <= quiet_pwm_autoscale;
            homing_busy_o <= (home_state == SAP_HOME_BUSY);
            homing_speed_o <= homing_speed;
        end
    end

    // Answer value and status for the frame now on the port.
    always_comb begin
        next_rsp_value = 32'h00000000;
        next_rsp_ok = 1'b1;
        if (wr) begin
            next_rsp_ok = wr_ok;
            next_rsp_value = v;
        end else if (cmd_i.op == SAP_OP_HOME) begin
            next_rsp_ok = (home_state == SAP_HOME_IDLE);
        end else if (cmd_i.op != SAP_OP_READ) begin
            next_rsp_ok = 1'b0;
        end else begin
            case (cmd_i.param)
                `SAP_P_STALL_THR: next_rsp_value = {{25{stall_threshold[6]}}, stall_threshold};
                `SAP_P_SENSE_RANGE: next_rsp_value = {31'h00000000, sense_range_select};
                `SAP_P_CUR_ACTUAL: next_rsp_value = {27'h0000000, current_scale_i};
                `SAP_P_STALL_SPEED: next_rsp_value = {9'h000, stall_stop_speed};
                `SAP_P_ADAPT_SPEED: next_rsp_value = {9'h000, adaptive_current_speed};
                `SAP_P_PWM_LIMIT: next_rsp_value = {9'h000, quiet_pwm_speed_limit};
                `SAP_P_PWM_GRAD: next_rsp_value = {28'h0000000, quiet_pwm_gradient};
                `SAP_P_PWM_AMPL: next_rsp_value = {24'h000000, quiet_pwm_amplitude};
                `SAP_P_PWM_SCALE: next_rsp_value = {24'h000000, pwm_scale_i};
                `SAP_P_PWM_FREQ: next_rsp_value = {30'h00000000, quiet_pwm_freq_select};
                `SAP_P_PWM_AUTO: next_rsp_value = {31'h00000000, quiet_pwm_autoscale};
                `SAP_P_HOME_THR: next_rsp_value =
                    {{25{homing_stall_threshold[6]}}, homing_stall_threshold};
                `SAP_P_HOME_SPEED: next_rsp_value = {9'h000, homing_speed};
                `SAP_P_HOME_MIN: next_rsp_value = {9'h000, homing_stall_min_speed};
                `SAP_P_END_DIST: next_rsp_value = {1'b0, end_stop_distance};
                `SAP_P_LOAD: next_rsp_value = {22'h000000, load_i};
                `SAP_P_STALL_FLAG: next_rsp_value = {31'h00000000, stall_stop_flag};
                `SAP_P_FAULTS: next_rsp_value = {24'h000000, driver_fault_flags};
                default: next_rsp_ok = 1'b0;
            endcase
        end
    end

    // Answer register: one answer per frame, one cycle after it.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_o <= '0;
        end else begin
            rsp_valid_o <= cmd_valid_i;
            if (cmd_valid_i) begin
                rsp_o.ok <= next_rsp_ok;
                rsp_o.value <= next_rsp_value;
            end
        end
    end
endmodule

// >>> sap_axis_bank_properties.sv
// Checker of the axis parameter bank, seeing only the bank's top ports.
// Assumes one clock and a synchronous active low reset.
`timescale 1ns/1ps
module sap_axis_bank_properties
    import sap_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire sap_cmd_s cmd_i,
    input wire logic rsp_valid_o,
    input wire sap_rsp_s rsp_o,
    input wire logic [22:0] actual_speed_i,
    input wire logic [9:0] load_i,
    input wire logic stop_motor_o,
    input wire logic quiet_pwm_en_o,
    input wire logic [3:0] pwm_gradient_o,
    input wire logic homing_start_o,
    input wire logic homing_busy_o,
    input wire logic homing_done_i
);
    // Every check runs on the one clock and rests while reset is low.
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // A frame is of interest when it writes these read-only parameters or reads the load.
    wire ro_wr = cmd_valid_i && cmd_i.op == SAP_OP_WRITE && cmd_i.param inside
        {8'hb4, 8'hbd, 8'hc4, 8'hce, 8'hcf, 8'hd0};
    wire ld_rd = cmd_valid_i && cmd_i.op == SAP_OP_READ && cmd_i.param == 8'hce;
    property p_rsp; rsp_valid_o == $past(cmd_valid_i); endproperty
    a_rsp: assert property (p_rsp) else $error("answer pulse off");
    property p_hold; !rsp_valid_o |-> $stable(rsp_o); endproperty
    a_hold: assert property (p_hold) else $error("answer moved");
    property p_ro; ro_wr |=> rsp_valid_o && !rsp_o.ok; endproperty
    a_ro: assert property (p_ro) else $error("read-only write taken");
    property p_load; ld_rd |=> rsp_o.value == {22'h0, $past(load_i)}; endproperty
    a_load: assert property (p_load) else $error("load readout wrong");
    property p_stop; load_i != 10'h0 || actual_speed_i == 23'h0 |=> !stop_motor_o; endproperty
    a_stop: assert property (p_stop) else $error("stop without cause");
    property p_grad; pwm_gradient_o == 4'h0 && $past(pwm_gradient_o) == 4'h0 |-> !quiet_pwm_en_o;
    endproperty
    a_grad: assert property (p_grad) else $error("quiet mode with zero gradient");
    // The busy output is a registered copy of the search state, so it follows the start pulse.
    property p_start; homing_start_o |=> homing_busy_o && !homing_start_o; endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_done; homing_busy_o && homing_done_i |-> ##2 !homing_busy_o; endproperty
    a_done: assert property (p_done) else $error("search did not end");
endmodule

// >>> sap_host_model.sv
// Host model: sends one command frame at a time and takes the answer.
// Assumes the bank registers the answer on the edge that takes the frame.
`timescale 1ns/1ps
module sap_host_model
    import sap_pkg::*;
(
    input wire logic clk_i,
    output logic cmd_valid_o,
    output sap_cmd_s cmd_o,
    input wire sap_rsp_s rsp_i
);
    // The port is idle from time zero.
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    // Homing settings are sent before the start, distance read after it
    task automatic send(input sap_op_e op, input logic [7:0] p, input logic [31:0] v,
        output sap_rsp_s r);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= '{op, p, v};
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        // Released lines must not keep the last frame.
        cmd_o <= sap_cmd_s'(~cmd_o);
        @(posedge clk_i);
        r = rsp_i;
    endtask
endmodule

// >>> test_stepper_axis_param_bank.sv
// Bench of the axis parameter bank against a table model of its parameters.
// Assumes the host model and the checker files are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD %0t mismatch %h %h", $time, a, b); end end
module test_stepper_axis_param_bank;
    import sap_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i, rsp_valid_o, step_pulse_i = 1'b0;
    logic homing_done_i = 1'b0, sense_range_o, stop_motor_o, adaptive_current_en_o;
    logic quiet_pwm_en_o, pwm_autoscale_o, homing_start_o, homing_busy_o;
    sap_cmd_s cmd_i;
    sap_rsp_s rsp_o, r;
    logic [22:0] actual_speed_i = '0, homing_speed_o;
    logic [9:0] load_i = 10'h001;
    logic [4:0] current_scale_i = '0;
    logic [7:0] pwm_scale_i = '0, pwm_amplitude_o;
    logic [6:0] fault_pins_i = '0, active_stall_threshold_o;
    logic [30:0] homing_distance_i = '0;
    logic [3:0] pwm_gradient_o;
    logic [1:0] pwm_freq_o;
    int n_fail = 0, checks_done = 0, lfsr = 88941;
    // Model: parameter numbers, legal ranges and the values the bank should hold.
    int pn[12] = '{'hae, 'hb3, 'hb5, 'hb6, 'hba, 'hbb, 'hbc, 'hbf, 'hc0, 'hc1, 'hc2, 'hc3};
    int lo[12] = '{-64, 0, 0, 0, 0, 0, 0, 0, 0, -63, 0, 0};
    int hi[12] = '{63, 1, 7999774, 7999774, 7999774, 15, 255, 3, 1, 63, 7999774, 7999774};
    int ex[12] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    int ro[6] = '{'hb4, 'hbd, 'hc4, 'hce, 'hcf, 'hd0};
    // A short stand-still window keeps the run brief.
    sap_axis_bank #(.STANDSTILL_CYCLES(21'h000010)) sap_axis_bank_inst (.*);
    sap_host_model sap_host_model_inst (.clk_i, .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i),
        .rsp_i(rsp_o));
    function automatic int rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr & 32'h7fffffff;
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic go(sap_op_e op, int p, int v);
        sap_host_model_inst.send(op, p[7:0], v, r);
    endtask
    // Write one entry, then read it back sign-extended; refused values leave it alone.
    task automatic put(int i, int v);
        logic ok;
        ok = v >= lo[i] && v <= hi[i];
        go(SAP_OP_WRITE, pn[i], v);
        `CHK(r.ok, ok)
        if (ok) ex[i] = v;
        go(SAP_OP_READ, pn[i], 0);
        `CHK(r.value, ex[i])
    endtask
    // Speed and load change together, then settle for three cycles.
    task automatic drive(int s, int l);
        actual_speed_i <= s[22:0];
        load_i <= l[9:0];
        tick(3);
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // A hang counts as a mismatch.
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
    initial begin
        tick(6);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            go(SAP_OP_READ, pn[i], 0);
            `CHK(r.value, ex[i])
            put(i, hi[i]);
            put(i, hi[i] + 1);
            put(i, lo[i] - 1);
            put(i, lo[i]);
            put(i, lo[i] + rnd() % (hi[i] - lo[i] + 1));
        end
        `CHK(pwm_amplitude_o, ex[6][7:0])
        `CHK(pwm_freq_o, ex[7][1:0])
        `CHK(pwm_autoscale_o, ex[8][0])
        `CHK(sense_range_o, ex[1][0])
        current_scale_i <= 5'(rnd());
        pwm_scale_i <= 8'(rnd());
        load_i <= 10'(rnd()) | 10'h001;
        foreach (ro[k]) begin
            go(SAP_OP_WRITE, ro[k], 1);
            `CHK(r.ok, 1'b0)
        end
        go(SAP_OP_READ, 'hb4, 0);
        `CHK(r.value, {27'h0, current_scale_i})
        go(SAP_OP_READ, 'hbd, 0);
        `CHK(r.value, {24'h0, pwm_scale_i})
        go(SAP_OP_READ, 'hce, 0);
        `CHK(r.value, {22'h0, load_i})
        step_pulse_i <= 1'b1;
        fault_pins_i <= 7'(rnd());
        tick(4);
        go(SAP_OP_READ, 'hd0, 0);
        `CHK(r.value, {25'h0, fault_pins_i})
        step_pulse_i <= 1'b0;
        tick(20);
        go(SAP_OP_READ, 'hd0, 0);
        `CHK(r.value, {24'h0, 1'b1, fault_pins_i})
        put(2, 100);
        drive(200, 0);
        `CHK(stop_motor_o, 1'b1)
        drive(100, 0);
        `CHK(stop_motor_o, 1'b0)
        drive(200, 5);
        go(SAP_OP_READ, 'hcf, 0);
        `CHK(r.value, 32'h00000001)
        go(SAP_OP_READ, 'hcf, 0);
        `CHK(r.value, 32'h00000000)
        put(3, 100);
        drive(101, 5);
        `CHK(adaptive_current_en_o, 1'b1)
        drive(100, 5);
        `CHK(adaptive_current_en_o, 1'b0)
        put(4, 100);
        put(5, 0);
        drive(50, 5);
        `CHK(quiet_pwm_en_o, 1'b0)
        put(5, 3);
        `CHK(quiet_pwm_en_o, 1'b1)
        drive(150, 5);
        `CHK(quiet_pwm_en_o, 1'b0)
        put(9, -5);
        put(10, 300);
        put(11, 1000);
        go(SAP_OP_HOME, 0, 0);
        `CHK(r.ok, 1'b1)
        tick(1);
        `CHK(homing_busy_o, 1'b1)
        `CHK(active_stall_threshold_o, 7'h7b)
        `CHK(homing_speed_o, 23'h00012c)
        go(SAP_OP_HOME, 0, 0);
        `CHK(r.ok, 1'b0)
        // While searching, the homing minimum speed governs, not the run stop speed.
        drive(500, 0);
        `CHK(stop_motor_o, 1'b0)
        drive(1001, 0);
        `CHK(stop_motor_o, 1'b1)
        drive(150, 5);
        homing_distance_i <= 31'(rnd());
        homing_done_i <= 1'b1;
        tick(1);
        homing_done_i <= 1'b0;
        tick(3);
        `CHK(homing_busy_o, 1'b0)
        go(SAP_OP_READ, 'hc4, 0);
        `CHK(r.value, {1'b0, homing_distance_i})
        give_verdict();
    end
endmodule
bind sap_axis_bank sap_axis_bank_properties sap_axis_bank_properties_inst (.*);
